// ### src/wsa_pkg.sv
package wsa_pkg;
  localparam int STEP_AW = 4;
  localparam int STEPS = 16;
  localparam int SEG_W = 8;
  localparam int REP_W = 20;
  localparam int ONCE_W = 20;
  localparam logic [REP_W-1:0] REP_MIN = 20'h00001;
  localparam logic [REP_W-1:0] REP_MAX = 20'hF4240;
  localparam logic [ONCE_W-1:0] ONCE_MAX = 20'hF4240;
  localparam logic [STEP_AW-1:0] STEP_FIRST = 4'h0;
  typedef enum logic [1:0] {WSA_ADV_AUTO, WSA_ADV_ONCE, WSA_ADV_STEPPED} wsa_adv_e;
  localparam wsa_adv_e ADV_RESET = WSA_ADV_AUTO;
  typedef enum logic [1:0] {WSA_RUN_CONT, WSA_RUN_TRIG, WSA_RUN_GATED} wsa_run_e;
  typedef enum logic [1:0] {WSA_IDLE, WSA_PLAY} wsa_state_e;
endpackage : wsa_pkg

// ### src/wsa_seq.sv
`timescale 1ns/1ps
// What this block does
// - auto mode walks the steps from the first to the last step in order, then wraps to the first; triggered run mode returns idle there
// - each step replays its segment repeat-count times before moving on
// - jump-flagged step loops until a jump event, then finishes and advances
// - advance mode resets to auto
// - once mode plays the table loop-count times per start, then returns idle
// - once mode repeats the pass a loop count of 1 to 1,000,000 times
// - in once mode every run mode honours the jump flag
// - stepped mode treats every jump flag as set
// - apply copies the edit table into working table and uses it at once
// - edits without apply stay unused until the function is re-entered
// - continuous, triggered and gated run modes combine with all advance modes
// - continuous: start at once when unarmed, else on bus or event enable, bus abort when armed, idle is first wave
// - triggered: idle is DC, start by panel, bus or trigger, bus abort when armed
// - outside stepped mode, jump flag 0 advances as soon as repeats are done
// - triggered: each trigger gives one playback (loop-count passes in once mode), then waits again
// - gated: output plays only while the gate is true
module wsa_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] adv_mode_i,
  input wire logic adv_mode_load_i,
  input wire logic [1:0] run_mode_i,
  input wire logic armed_i,
  input wire logic [19:0] once_count_i,
  input wire logic [3:0] last_step_i,
  input wire logic edit_we_i,
  input wire logic [3:0] edit_addr_i,
  input wire logic [7:0] edit_seg_i,
  input wire logic [19:0] edit_rep_i,
  input wire logic edit_jump_i,
  input wire logic apply_i,
  input wire logic func_enter_i,
  input wire logic bus_enable_i,
  input wire logic bus_abort_i,
  input wire logic bus_init_i,
  input wire logic panel_init_i,
  input wire logic jump_pin_i,
  input wire logic event_pin_i,
  input wire logic trig_pin_i,
  input wire logic gate_pin_i,
  input wire logic wave_end_i,
  output logic running_o,
  output logic idle_dc_o,
  output logic [7:0] seg_o,
  output logic [3:0] step_o,
  output logic [1:0] adv_mode_o
);
  localparam int N = wsa_pkg::STEPS;
  typedef struct packed {
    wsa_pkg::wsa_state_e st;
    wsa_pkg::wsa_adv_e adv;
    logic [N-1:0][7:0] e_seg;
    logic [N-1:0][19:0] e_rep;
    logic [N-1:0] e_jmp;
    logic [N-1:0][7:0] w_seg;
    logic [N-1:0][19:0] w_rep;
    logic [N-1:0] w_jmp;
    logic [3:0] w_last;
    logic [3:0] step;
    logic [19:0] rep;
    logic [19:0] once_left;
    logic jump_seen;
    logic idle_dc;
    logic running;
    logic [7:0] seg;
  } wsa_seq_s;
  wsa_seq_s q;
  wsa_seq_s next_q;
  wsa_sync_if sif ();
  assign sif.jump_pin = jump_pin_i;
  assign sif.event_pin = event_pin_i;
  assign sif.trig_pin = trig_pin_i;
  assign sif.gate_pin = gate_pin_i;
  wsa_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(sif.snk)
  );
  logic start;
  logic gate_ok;
  logic need_jump;
  logic step_done;
  logic at_last;
  always_comb begin
    start = 1'b0;
    case (run_mode_i)
      wsa_pkg::WSA_RUN_CONT: start = !armed_i || bus_enable_i || sif.event_rise;
      wsa_pkg::WSA_RUN_TRIG: start = panel_init_i || bus_init_i || sif.trig_rise;
      wsa_pkg::WSA_RUN_GATED: start = sif.gate_lvl;
      default: start = 1'b0;
    endcase
    gate_ok = (run_mode_i != wsa_pkg::WSA_RUN_GATED) || sif.gate_lvl;
    need_jump = (q.adv == wsa_pkg::WSA_ADV_STEPPED) || q.w_jmp[q.step];
    step_done = wave_end_i && (q.rep <= 20'h00001) && (!need_jump || q.jump_seen || sif.jump_rise);
    at_last = q.step == q.w_last;
  end
  always_comb begin
    next_q = q;
    if (adv_mode_load_i && adv_mode_i <= 2'h2) begin
      next_q.adv = wsa_pkg::wsa_adv_e'(adv_mode_i);
    end
    if (edit_we_i) begin
      next_q.e_seg[edit_addr_i] = edit_seg_i;
      next_q.e_rep[edit_addr_i] = (edit_rep_i == 20'h00000) ? wsa_pkg::REP_MIN :
        (edit_rep_i > wsa_pkg::REP_MAX) ? wsa_pkg::REP_MAX : edit_rep_i;
      next_q.e_jmp[edit_addr_i] = edit_jump_i;
    end
    if (apply_i || func_enter_i) begin
      next_q.w_seg = next_q.e_seg;
      next_q.w_rep = next_q.e_rep;
      next_q.w_jmp = next_q.e_jmp;
      next_q.w_last = last_step_i;
      next_q.step = wsa_pkg::STEP_FIRST;
      next_q.rep = next_q.e_rep[0];
      next_q.jump_seen = 1'b0;
    end else if (bus_abort_i && armed_i) begin
      next_q.st = wsa_pkg::WSA_IDLE;
      next_q.step = wsa_pkg::STEP_FIRST;
      next_q.rep = q.w_rep[0];
    end else begin
      case (q.st)
        wsa_pkg::WSA_IDLE: begin
          next_q.jump_seen = 1'b0;
          next_q.rep = q.w_rep[0];
          next_q.step = wsa_pkg::STEP_FIRST;
          next_q.once_left = (once_count_i == 20'h00000) ? 20'h00001 :
            (once_count_i > wsa_pkg::ONCE_MAX) ? wsa_pkg::ONCE_MAX : once_count_i;
          if (start) begin
            next_q.st = wsa_pkg::WSA_PLAY;
          end
        end
        wsa_pkg::WSA_PLAY: begin
          if (!gate_ok) begin
            next_q.st = wsa_pkg::WSA_IDLE;
          end else begin
            if (sif.jump_rise && need_jump) begin
              next_q.jump_seen = 1'b1;
            end
            if (wave_end_i && q.rep > 20'h00001) begin
              next_q.rep = q.rep - 20'h00001;
            end else if (step_done) begin
              next_q.jump_seen = 1'b0;
              next_q.step = at_last ? wsa_pkg::STEP_FIRST : q.step + 4'h1;
              next_q.rep = q.w_rep[at_last ? wsa_pkg::STEP_FIRST : q.step + 4'h1];
              if (at_last && q.adv == wsa_pkg::WSA_ADV_ONCE) begin
                if (q.once_left <= 20'h00001) begin
                  next_q.st = wsa_pkg::WSA_IDLE;
                end else begin
                  next_q.once_left = q.once_left - 20'h00001;
                end
              end else if (at_last && run_mode_i == wsa_pkg::WSA_RUN_TRIG) begin
                next_q.st = wsa_pkg::WSA_IDLE;
              end
            end
          end
        end
        default: next_q.st = wsa_pkg::WSA_IDLE;
      endcase
    end
    next_q.idle_dc = (next_q.st == wsa_pkg::WSA_IDLE) && (run_mode_i != wsa_pkg::WSA_RUN_CONT);
    next_q.running = (next_q.st == wsa_pkg::WSA_PLAY);
    next_q.seg = next_q.w_seg[next_q.step];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= wsa_pkg::WSA_IDLE;
      q.adv <= wsa_pkg::ADV_RESET;
    end else begin
      q <= next_q;
    end
  end
  assign running_o = q.running;
  assign idle_dc_o = q.idle_dc;
  assign seg_o = q.seg;
  assign step_o = q.step;
  assign adv_mode_o = q.adv;

  sequence s_flag_wave_end;
    q.st == wsa_pkg::WSA_PLAY && need_jump && !q.jump_seen && !sif.jump_rise && wave_end_i && q.rep <= 20'h00001;
  endsequence
  hold_on_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_flag_wave_end and (!apply_i && !func_enter_i && !bus_abort_i && gate_ok)) |=> $stable(q.step))
    else $error("flagged step advanced without jump");
  // an unflagged step leaves as soon as its last replay ends
  sequence s_plain_last_end;
    q.st == wsa_pkg::WSA_PLAY && !need_jump && wave_end_i && q.rep <= 20'h00001;
  endsequence
  plain_advance_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_plain_last_end and (!apply_i && !func_enter_i && !bus_abort_i && gate_ok && !at_last))
    |=> q.step == $past(q.step) + 4'h1)
    else $error("unflagged step did not advance");
  auto_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    step_done && at_last && q.st == wsa_pkg::WSA_PLAY && gate_ok && !apply_i && !func_enter_i && !bus_abort_i
    |=> q.step == wsa_pkg::STEP_FIRST)
    else $error("no wrap after last step");
  trig_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run_mode_i == wsa_pkg::WSA_RUN_TRIG && q.adv != wsa_pkg::WSA_ADV_ONCE && q.st == wsa_pkg::WSA_PLAY && step_done
    && at_last && !apply_i && !func_enter_i && !bus_abort_i |=> !running_o)
    else $error("trigger gave more than one pass");
  repeat_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.st == wsa_pkg::WSA_PLAY && wave_end_i && q.rep > 20'h00001 && gate_ok && !apply_i && !func_enter_i && !bus_abort_i
    |=> $stable(q.step) && q.rep == $past(q.rep) - 20'h00001)
    else $error("repeat count not honoured");
  reset_auto_a: assert property (@(posedge clk_i) $past(rst_i) |-> q.adv == wsa_pkg::WSA_ADV_AUTO)
    else $error("advance mode not auto after reset");
  once_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.adv == wsa_pkg::WSA_ADV_ONCE && step_done && at_last && q.once_left <= 20'h00001 && q.st == wsa_pkg::WSA_PLAY
    && gate_ok && !apply_i && !func_enter_i && !bus_abort_i |=> q.st == wsa_pkg::WSA_IDLE)
    else $error("once mode kept running");
  apply_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
    apply_i && !edit_we_i |=> q.w_seg == $past(q.e_seg) && q.step == wsa_pkg::STEP_FIRST)
    else $error("apply did not load table");
  no_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !apply_i && !func_enter_i |=> $stable(q.w_seg))
    else $error("working table changed without apply");
  gate_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run_mode_i == wsa_pkg::WSA_RUN_GATED && !sif.gate_lvl && !apply_i && !func_enter_i ##1 !sif.gate_lvl
    |-> !running_o)
    else $error("playing with gate false");
  abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_abort_i && armed_i && !apply_i && !func_enter_i |=> !running_o)
    else $error("abort ignored");
endmodule : wsa_seq

// ### src/wsa_sync.sv
`timescale 1ns/1ps
module wsa_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  wsa_sync_if.snk s
);
  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] c;
    logic [3:0] rise;
    logic [3:0] lvl;
  } wsa_sync_s;
  wsa_sync_s q;
  wsa_sync_s next_q;
  logic [3:0] pins;
  assign pins = {s.gate_pin, s.trig_pin, s.event_pin, s.jump_pin};
  always_comb begin
    next_q = q;
    next_q.a = pins;
    next_q.b = q.a;
    next_q.c = q.b;
    next_q.rise = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (q.b[i] == q.c[i]) begin
        next_q.rise[i] = q.c[i] & ~q.lvl[i];
        next_q.lvl[i] = q.c[i];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign s.jump_rise = q.rise[0];
  assign s.event_rise = q.rise[1];
  assign s.trig_rise = q.rise[2];
  assign s.gate_lvl = q.lvl[3];
  jump_single_a: assert property (@(posedge clk_i) disable iff (rst_i) q.rise[0] |=> !q.rise[0])
    else $error("jump pulse longer than one cycle");
endmodule : wsa_sync

// ### src/wsa_sync_if.sv
`timescale 1ns/1ps
interface wsa_sync_if;
  logic jump_pin;
  logic event_pin;
  logic trig_pin;
  logic gate_pin;
  logic jump_rise;
  logic event_rise;
  logic trig_rise;
  logic gate_lvl;
  modport src (output jump_pin, event_pin, trig_pin, gate_pin, input jump_rise, event_rise, trig_rise, gate_lvl);
  modport snk (input jump_pin, event_pin, trig_pin, gate_pin, output jump_rise, event_rise, trig_rise, gate_lvl);
endinterface : wsa_sync_if

// ### tb/wsa_seq_tb.sv
`timescale 1ns/1ps
module wsa_seq_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] adv_mode_i = 2'h0, run_mode_i = 2'h0;
  logic adv_mode_load_i = 1'b0, armed_i = 1'b1, edit_we_i = 1'b0, edit_jump_i = 1'b0;
  logic [19:0] once_count_i = 20'h00001, edit_rep_i = 20'h00001;
  logic [3:0] last_step_i = 4'h2, edit_addr_i = 4'h0;
  logic [7:0] edit_seg_i = 8'h00;
  logic apply_i = 1'b0, func_enter_i = 1'b0, bus_enable_i = 1'b0, bus_abort_i = 1'b0;
  logic bus_init_i = 1'b0, panel_init_i = 1'b0, wave_end_i = 1'b0;
  logic jump_pin_i = 1'b0, event_pin_i = 1'b0, trig_pin_i = 1'b0, gate_pin_i = 1'b0;
  logic running_o, idle_dc_o;
  logic [7:0] seg_o;
  logic [3:0] step_o;
  logic [1:0] adv_mode_o;
  int failures = 0;
  int cmp_count = 0;
  wsa_seq dut (.clk_i(clk_i), .rst_i(rst_i), .adv_mode_i(adv_mode_i), .adv_mode_load_i(adv_mode_load_i),
    .run_mode_i(run_mode_i), .armed_i(armed_i), .once_count_i(once_count_i), .last_step_i(last_step_i),
    .edit_we_i(edit_we_i), .edit_addr_i(edit_addr_i), .edit_seg_i(edit_seg_i), .edit_rep_i(edit_rep_i),
    .edit_jump_i(edit_jump_i), .apply_i(apply_i), .func_enter_i(func_enter_i), .bus_enable_i(bus_enable_i),
    .bus_abort_i(bus_abort_i), .bus_init_i(bus_init_i), .panel_init_i(panel_init_i), .jump_pin_i(jump_pin_i),
    .event_pin_i(event_pin_i), .trig_pin_i(trig_pin_i), .gate_pin_i(gate_pin_i), .wave_end_i(wave_end_i),
    .running_o(running_o), .idle_dc_o(idle_dc_o), .seg_o(seg_o), .step_o(step_o), .adv_mode_o(adv_mode_o));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task check(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle strobe launched and dropped on falling edges
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    @(negedge clk_i);
  endtask : pulse
  // async pin: hold high long enough for the synchroniser, then let the edge land
  task automatic pin(ref logic s);
    s = 1'b1;
    repeat (3) @(negedge clk_i);
    s = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask : pin
  task wends(input int n);
    repeat (n) pulse(wave_end_i);
  endtask : wends
  task wait_run(input logic v);
    int i;
    for (i = 0; i < 20 && running_o !== v; i++) @(negedge clk_i);
    check(running_o, v);
    if (running_o !== v) finish_test();
  endtask : wait_run
  task wr(input logic [3:0] a, input logic [7:0] sg, input logic [19:0] rp, input logic jf);
    edit_addr_i = a;
    edit_seg_i = sg;
    edit_rep_i = rp;
    edit_jump_i = jf;
    pulse(edit_we_i);
  endtask : wr
  task set_adv(input logic [1:0] m);
    adv_mode_i = m;
    pulse(adv_mode_load_i);
    check(adv_mode_o, m);
  endtask : set_adv
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check(adv_mode_o, wsa_pkg::WSA_ADV_AUTO);
    check(running_o, 1'b0);
    check(idle_dc_o, 1'b0);
    wr(4'h0, 8'h11, 20'h00002, 1'b0);
    wr(4'h1, 8'h22, 20'h00001, 1'b0);
    wr(4'h2, 8'h33, 20'h00001, 1'b0);
    pulse(apply_i);
    check(seg_o, 8'h11);
    pulse(bus_enable_i);
    wait_run(1'b1);
    wends(1);
    check(step_o, 4'h0);
    wends(1);
    check(step_o, 4'h1);
    wends(2);
    check(step_o, 4'h0);
    wr(4'h0, 8'h44, 20'h00002, 1'b0);
    wends(4);
    check(seg_o, 8'h11);
    pulse(apply_i);
    check(seg_o, 8'h44);
    check(step_o, 4'h0);
    wr(4'h1, 8'h22, 20'h00001, 1'b1);
    wr(4'h2, 8'h33, 20'h00001, 1'b1);
    pulse(apply_i);
    wends(5);
    check(step_o, 4'h1);
    pin(jump_pin_i);
    wends(1);
    check(step_o, 4'h2);
    wends(2);
    check(step_o, 4'h2);
    pulse(bus_abort_i);
    wait_run(1'b0);
    set_adv(wsa_pkg::WSA_ADV_STEPPED);
    wr(4'h1, 8'h22, 20'h00001, 1'b0);
    wr(4'h2, 8'h33, 20'h00001, 1'b0);
    pulse(apply_i);
    pin(event_pin_i);
    wait_run(1'b1);
    wends(3);
    check(step_o, 4'h0);
    pin(jump_pin_i);
    wends(2);
    check(step_o, 4'h1);
    pulse(bus_abort_i);
    wait_run(1'b0);
    set_adv(wsa_pkg::WSA_ADV_ONCE);
    once_count_i = 20'h00002;
    pulse(func_enter_i);
    pulse(bus_enable_i);
    wait_run(1'b1);
    wends(7);
    check(running_o, 1'b1);
    wends(1);
    wait_run(1'b0);
    check(seg_o, 8'h44);
    set_adv(wsa_pkg::WSA_ADV_AUTO);
    run_mode_i = wsa_pkg::WSA_RUN_TRIG;
    @(negedge clk_i);
    check(idle_dc_o, 1'b1);
    pin(trig_pin_i);
    wait_run(1'b1);
    check(idle_dc_o, 1'b0);
    wends(4);
    wait_run(1'b0);
    pulse(panel_init_i);
    wait_run(1'b1);
    wends(4);
    wait_run(1'b0);
    pulse(bus_init_i);
    wait_run(1'b1);
    pulse(bus_abort_i);
    wait_run(1'b0);
    run_mode_i = wsa_pkg::WSA_RUN_GATED;
    gate_pin_i = 1'b1;
    wait_run(1'b1);
    wends(2);
    gate_pin_i = 1'b0;
    wait_run(1'b0);
    run_mode_i = wsa_pkg::WSA_RUN_CONT;
    armed_i = 1'b0;
    wait_run(1'b1);
    pulse(bus_abort_i);
    check(running_o, 1'b1);
    adv_mode_i = 2'h3;
    pulse(adv_mode_load_i);
    check(adv_mode_o, wsa_pkg::WSA_ADV_AUTO);
    finish_test();
  end
endmodule : wsa_seq_tb
